// >>> hw/lpb_channel_bank.sv
// lpb_channel_bank: write-only two-wire register bank driving 18 pwm sinks
// assumes: scl, sda, strap and shutdown pins are asynchronous to clk_in;
// the bench resolves the open-drain data wire from sda_oe_out
`include "lpb_params.svh"
module lpb_channel_bank
  import lpb_pkg::*;
#(
  parameter int NUM_CH = `LPB_NUM_CH
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_strap_in,
  input wire logic hw_shutdown_n_in,
  output logic [NUM_CH-1:0] led_sink_outputs_out,
  output logic [NUM_CH-1:0][4:0] sink_level_out
);

  localparam int FAST_DIV =
    `LPB_CLK_HZ / (`LPB_FAST_PWM_HZ * `LPB_PWM_STEPS);
  localparam int SLOW_DIV =
    `LPB_CLK_HZ / (`LPB_SLOW_PWM_HZ * `LPB_PWM_STEPS);
  localparam logic [7:0] FAST_LAST = 8'(FAST_DIV - 1);
  localparam logic [7:0] SLOW_LAST = 8'(SLOW_DIV - 1);

  // scale code to numerator of the 1/24 current fraction
  function automatic logic [4:0] scale_num(input logic [5:0] code);
    logic [4:0] n;
    n = 5'h00;
    unique case (code)
      `LPB_SC_FULL: n = 5'h18;
      `LPB_SC_23: n = 5'h17;
      `LPB_SC_22: n = 5'h16;
      `LPB_SC_21: n = 5'h15;
      `LPB_SC_20: n = 5'h14;
      `LPB_SC_19: n = 5'h13;
      `LPB_SC_18: n = 5'h12;
      `LPB_SC_16: n = 5'h10;
      `LPB_SC_14: n = 5'h0e;
      `LPB_SC_12: n = 5'h0c;
      `LPB_SC_11: n = 5'h0b;
      `LPB_SC_9: n = 5'h09;
      `LPB_SC_7: n = 5'h07;
      default: n = 5'h00;
    endcase
    return n;
  endfunction : scale_num

  // true when addr lies within [first, last]
  function automatic logic in_range(input logic [7:0] addr,
                                    input logic [7:0] first,
                                    input logic [7:0] last);
    return (addr >= first) && (addr <= last);
  endfunction : in_range

  // pin synchronisers: scl, sda, hw shutdown, strap
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  always_ff @(posedge clk_in) begin
    pin_meta_reg <= {addr_strap_in, hw_shutdown_n_in, sda_in, scl_in};
    pin_sync_reg <= pin_meta_reg;
    scl_prev_reg <= pin_sync_reg[0];
    sda_prev_reg <= pin_sync_reg[1];
  end
  wire scl_s = pin_sync_reg[0];
  wire sda_s = pin_sync_reg[1];
  wire hw_run = pin_sync_reg[2];
  wire [1:0] strap_s = pin_sync_reg[4:3];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire bus_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // two-wire slave, receive only
  lpb_slave_state_t state_reg;
  lpb_byte_kind_t kind_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic byte_full_reg;
  logic [7:0] ptr_reg;
  lpb_wr_t wr_reg;
  logic sda_oe_reg;

  wire byte_end = (state_reg == LPB_RECV) && scl_fall && byte_full_reg;
  wire dev_match =
    (shift_reg == {`LPB_DEV_PREFIX, strap_s, 1'b0});
  wire take_data = byte_end && (kind_reg == LPB_BYTE_DATA);
  logic ack_now;
  lpb_byte_kind_t kind_next;
  always_comb begin
    ack_now = 1'b1;
    kind_next = kind_reg;
    unique case (kind_reg)
      LPB_BYTE_DEV: begin
        ack_now = dev_match;
        kind_next = LPB_BYTE_REG;
      end
      LPB_BYTE_REG: kind_next = LPB_BYTE_DATA;
      LPB_BYTE_DATA: kind_next = LPB_BYTE_DATA;
      default: ack_now = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || bus_stop) begin
      state_reg <= LPB_IDLE;
      sda_oe_reg <= 1'b0;
      byte_full_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg <= LPB_RECV;
      kind_reg <= LPB_BYTE_DEV;
      bit_cnt_reg <= 3'h0;
      byte_full_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (state_reg == LPB_RECV && scl_rise && !byte_full_reg) begin
      shift_reg <= {shift_reg[6:0], sda_s};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      byte_full_reg <= (bit_cnt_reg == `LPB_LAST_BIT);
    end else if (byte_end) begin
      byte_full_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      kind_reg <= kind_next;
      state_reg <= ack_now ? LPB_ACK : LPB_IGNORE;
      sda_oe_reg <= ack_now;
    end else if (state_reg == LPB_ACK && scl_fall) begin
      state_reg <= LPB_RECV;
      sda_oe_reg <= 1'b0;
    end
    if (sys_rst_in) begin
      kind_reg <= LPB_BYTE_DEV;
      bit_cnt_reg <= 3'h0;
      shift_reg <= `LPB_RESET_VALUE;
    end
  end

  // register pointer and write strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ptr_reg <= `LPB_RESET_VALUE;
      wr_reg <= '0;
    end else begin
      wr_reg.valid <= take_data;
      wr_reg.addr <= ptr_reg;
      wr_reg.data <= shift_reg;
      if (byte_end && kind_reg == LPB_BYTE_REG)
        ptr_reg <= shift_reg;
      else if (take_data)
        ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // register decode
  wire wr_en = wr_reg.valid;
  wire [7:0] wa = wr_reg.addr;
  wire [7:0] wd = wr_reg.data;
  wire trig_zero = (wd == `LPB_TRIGGER_VALUE);
  wire commit = wr_en && wa == `LPB_REG_COMMIT && trig_zero;
  wire reg_reset = wr_en && wa == `LPB_REG_RESET && trig_zero;
  wire duty_hit =
    wr_en && in_range(wa, `LPB_REG_DUTY_FIRST, `LPB_REG_DUTY_LAST);
  wire scale_hit =
    wr_en && in_range(wa, `LPB_REG_SCALE_FIRST, `LPB_REG_SCALE_LAST);
  wire [7:0] duty_off = wa - `LPB_REG_DUTY_FIRST;
  wire [7:0] scale_off = wa - `LPB_REG_SCALE_FIRST;
  wire [4:0] duty_idx = duty_off[4:0];
  wire [4:0] scale_idx = scale_off[4:0];

  logic soft_shutdown_n_reg;
  logic all_outputs_off_reg;
  logic pwm_freq_select_reg;
  logic [NUM_CH-1:0][7:0] duty_shadow_reg;
  logic [NUM_CH-1:0][7:0] duty_active_reg;
  logic [NUM_CH-1:0][5:0] scale_shadow_reg;
  logic [NUM_CH-1:0][5:0] scale_active_reg;

  // register file; shutdown leaves contents untouched
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || reg_reset) begin
      soft_shutdown_n_reg <= 1'b0;
      all_outputs_off_reg <= 1'b0;
      pwm_freq_select_reg <= 1'b0;
      duty_shadow_reg <= '0;
      duty_active_reg <= '0;
      scale_shadow_reg <= '0;
      scale_active_reg <= '0;
    end else begin
      if (wr_en && wa == `LPB_REG_SHUTDOWN)
        soft_shutdown_n_reg <= wd[`LPB_CTRL_BIT];
      if (wr_en && wa == `LPB_REG_GLOBAL)
        all_outputs_off_reg <= wd[`LPB_CTRL_BIT];
      if (wr_en && wa == `LPB_REG_FREQ)
        pwm_freq_select_reg <= wd[`LPB_CTRL_BIT];
      if (duty_hit)
        duty_shadow_reg[duty_idx] <= wd;
      if (scale_hit)
        scale_shadow_reg[scale_idx] <= wd[`LPB_SCALE_MSB:0];
      if (commit) begin
        duty_active_reg <= duty_shadow_reg;
        scale_active_reg <= scale_shadow_reg;
      end
    end
  end

  // step divider and shared period counter
  logic [7:0] div_cnt_reg;
  logic [7:0] pwm_cnt_reg;
  wire [7:0] div_last = pwm_freq_select_reg ? SLOW_LAST : FAST_LAST;
  wire step_en = (div_cnt_reg >= div_last);
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_cnt_reg <= 8'h00;
      pwm_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= step_en ? 8'h00 : div_cnt_reg + 8'h01;
      if (step_en)
        pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // channel outputs
  wire run =
    soft_shutdown_n_reg && !all_outputs_off_reg && hw_run;
  logic [NUM_CH-1:0] sink_next;
  logic [NUM_CH-1:0][4:0] level_next;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire [4:0] num = scale_num(scale_active_reg[i]);
    assign sink_next[i] = run && (num != 5'h00) &&
      (pwm_cnt_reg < duty_active_reg[i]);
    assign level_next[i] = sink_next[i] ? num : 5'h00;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      led_sink_outputs_out <= '0;
      sink_level_out <= '0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      led_sink_outputs_out <= sink_next;
      sink_level_out <= level_next;
      sda_out <= 1'b0;
      sda_oe_out <= sda_oe_reg;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence dev_byte_done;
    byte_end && kind_reg == LPB_BYTE_DEV;
  endsequence
  sequence data_byte_done;
    take_data;
  endsequence

  soft_off_a: assert property (
    !soft_shutdown_n_reg |=> led_sink_outputs_out == '0)
    else $error("sink on during software shutdown");
  global_off_a: assert property (
    all_outputs_off_reg |=> led_sink_outputs_out == '0)
    else $error("sink on while global off set");
  hw_off_a: assert property (
    !hw_run |=> led_sink_outputs_out == '0)
    else $error("sink on during hardware shutdown");
  commit_copy_a: assert property (
    commit |=> duty_active_reg == $past(duty_shadow_reg))
    else $error("shadow duty not committed");
  shadow_hold_a: assert property (
    !commit && !reg_reset |=> $stable(duty_active_reg))
    else $error("active duty changed without commit");
  bad_trig_a: assert property (
    wr_en && !trig_zero |=> $stable(scale_active_reg))
    else $error("nonzero trigger acted");
  reg_clear_a: assert property (
    reg_reset |=> duty_shadow_reg == '0 && !soft_shutdown_n_reg)
    else $error("register reset incomplete");
  ptr_step_a: assert property (
    data_byte_done |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("pointer did not advance");
  dev_ack_a: assert property (
    dev_byte_done ##0 dev_match |=> ##1 sda_oe_out)
    else $error("matching address not acknowledged");
  pwm_on_a: assert property (
    run && scale_active_reg[0] == `LPB_SC_FULL &&
    pwm_cnt_reg < duty_active_reg[0] |=> led_sink_outputs_out[0])
    else $error("channel off below duty");
  pwm_off_a: assert property (
    pwm_cnt_reg >= duty_active_reg[0] |=> !led_sink_outputs_out[0])
    else $error("channel on at or above duty");

endmodule : lpb_channel_bank

// >>> hw/lpb_params.svh
// lpb_params.svh: addresses, reset values and timing figures of the bank
// assumes: included by the package and by the bank module
`ifndef LPB_PARAMS_SVH
`define LPB_PARAMS_SVH
`define LPB_NUM_CH 18
`define LPB_REG_SHUTDOWN 8'h00
`define LPB_REG_DUTY_FIRST 8'h01
`define LPB_REG_DUTY_LAST 8'h12
`define LPB_REG_COMMIT 8'h13
`define LPB_REG_SCALE_FIRST 8'h14
`define LPB_REG_SCALE_LAST 8'h25
`define LPB_REG_GLOBAL 8'h26
`define LPB_REG_FREQ 8'h27
`define LPB_REG_RESET 8'h2f
`define LPB_TRIGGER_VALUE 8'h00
`define LPB_RESET_VALUE 8'h00
`define LPB_CTRL_BIT 0
`define LPB_SCALE_MSB 5
`define LPB_DEV_PREFIX 5'h1b
`define LPB_CLK_HZ 200000000
`define LPB_FAST_PWM_HZ 23000
`define LPB_SLOW_PWM_HZ 3450
`define LPB_PWM_STEPS 256
`define LPB_LAST_BIT 3'h7
`define LPB_SC_FULL 6'h30
`define LPB_SC_23 6'h31
`define LPB_SC_22 6'h35
`define LPB_SC_21 6'h32
`define LPB_SC_20 6'h36
`define LPB_SC_19 6'h33
`define LPB_SC_18 6'h3a
`define LPB_SC_16 6'h3b
`define LPB_SC_14 6'h3f
`define LPB_SC_12 6'h10
`define LPB_SC_11 6'h11
`define LPB_SC_9 6'h12
`define LPB_SC_7 6'h13
`endif

// >>> hw/lpb_pkg.sv
// lpb_pkg: types shared by the led pwm channel bank
// assumes: lpb_params.svh is on the include path
package lpb_pkg;
  `include "lpb_params.svh"
  typedef enum logic [1:0] {
    LPB_IDLE = 2'b00,
    LPB_RECV = 2'b01,
    LPB_ACK = 2'b10,
    LPB_IGNORE = 2'b11
  } lpb_slave_state_t;
  typedef enum logic [1:0] {
    LPB_BYTE_DEV = 2'b00,
    LPB_BYTE_REG = 2'b01,
    LPB_BYTE_DATA = 2'b10
  } lpb_byte_kind_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lpb_wr_t;
endpackage : lpb_pkg

// >>> test/lpb_host_model.sv
// lpb_host_model: two-wire bus master that writes the channel bank
// assumes: bench clock on clk_in; the bench resolves the pulled-up data wire
module lpb_host_model (
  input wire logic clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold
  // one clock pulse; data moves well inside the low phase
  task automatic pulse(input logic b, output logic ack);
    scl_out <= 1'b0;
    hold(6);
    sda_low_out <= !b;
    hold(2);
    scl_out <= 1'b1;
    hold(4);
    ack = !sda_line_in;
    hold(4);
  endtask : pulse
  task automatic xfer(input logic [7:0] q [$], output int acks);
    logic a;
    acks = 0;
    sda_low_out <= 1'b1;
    hold(8);
    foreach (q[k]) begin
      for (int i = 7; i >= 0; i--) pulse(q[k][i], a);
      pulse(1'b1, a);
      acks += a;
      if (!a) break;
    end
    scl_out <= 1'b0;
    hold(6);
    sda_low_out <= 1'b1;
    hold(2);
    scl_out <= 1'b1;
    hold(4);
    sda_low_out <= 1'b0;
    hold(8);
  endtask : xfer
endmodule : lpb_host_model

// >>> test/tb.sv
// tb: self-checking bench for the led pwm channel bank
// assumes: lpb_host_model drives the bus; 200 MHz clock
`include "lpb_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hw_n = 1'b1;
  logic [1:0] strap = 2'b10;
  logic scl, host_low, sda_oe, sda_drv, sda_line;
  logic [17:0] leds;
  logic [17:0][4:0] lvl;
  logic [7:0] duty_a [18];
  logic [4:0] lvl_a [18];
  logic [7:0] q [$];
  logic [31:0] seed = 32'h78b5;
  logic [5:0] codes [14] = '{6'h30, 6'h31, 6'h35, 6'h32, 6'h36, 6'h33,
    6'h3a, 6'h3b, 6'h3f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h05};
  int miscompares = 0, tests_run = 0, cyc = 0, acks, stepc;
  assign sda_line = !(host_low || (sda_oe && !sda_drv));
  lpb_channel_bank dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .addr_strap_in(strap), .hw_shutdown_n_in(hw_n),
    .led_sink_outputs_out(leds), .sink_level_out(lvl));
  lpb_host_model host_u (.clk_in(clk_in), .sda_line_in(sda_line),
    .scl_out(scl), .sda_low_out(host_low));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [4:0] level(input logic [5:0] c);
    case (c)
      6'h30: return 5'h18;
      6'h31: return 5'h17;
      6'h35: return 5'h16;
      6'h32: return 5'h15;
      6'h36: return 5'h14;
      6'h33: return 5'h13;
      6'h3a: return 5'h12;
      6'h3b: return 5'h10;
      6'h3f: return 5'h0e;
      6'h10: return 5'h0c;
      6'h11: return 5'h0b;
      6'h12: return 5'h09;
      6'h13: return 5'h07;
      default: return 5'h00;
    endcase
  endfunction : level
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] a);
    q.push_front(a);
    q.push_front({5'h1b, strap, 1'b0});
    host_u.xfer(q, acks);
    check(acks, q.size());
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    q.delete();
    q.push_back(d);
    send(a);
  endtask : wr
  task automatic measure(input int win, input logic run, input string nm);
    int on_cnt [18];
    int bad;
    logic [17:0] prev, en_m;
    bad = 0;
    prev = leds;
    for (int i = 0; i < 18; i++) begin
      on_cnt[i] = 0;
      en_m[i] = run && lvl_a[i] != 5'h00 && duty_a[i] != 8'h00;
    end
    repeat (win) begin
      @(posedge clk_in);
      if ((leds & ~prev) != 18'h0 && leds !== en_m) bad++;
      if ((leds & ~en_m) !== 18'h0) bad++;
      for (int i = 0; i < 18; i++) begin
        on_cnt[i] += leds[i];
        if (leds[i] && lvl[i] !== lvl_a[i]) bad++;
      end
      prev = leds;
    end
    check(bad, 0);
    for (int i = 0; i < 18; i++) begin
      check(on_cnt[i], en_m[i] ? duty_a[i] * stepc : 0);
    end
    $display("test %s done", nm);
  endtask : measure
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    logic [5:0] c;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    strap <= 2'(rnd());
    repeat (3) @(posedge clk_in);
    stepc = `LPB_CLK_HZ / (`LPB_FAST_PWM_HZ * `LPB_PWM_STEPS);
    foreach (duty_a[i]) begin
      duty_a[i] = 8'h00;
      lvl_a[i] = 5'h00;
    end
    measure(1000, 1'b1, "reset");
    q.delete();
    q.push_back(8'h01);
    for (int i = 0; i < 18; i++) begin
      duty_a[i] = (i == 0) ? 8'hff : (i == 1) ? 8'h04 : 8'(rnd());
      q.push_back(duty_a[i]);
    end
    q.push_back(8'h01);
    for (int i = 0; i < 18; i++) begin
      c = (i < 14) ? codes[i] : 6'(rnd());
      lvl_a[i] = level(c);
      q.push_back({2'b11, c});
    end
    send(8'h00);
    measure(1000, 1'b0, "shadow");
    wr(8'h13, 8'h00);
    measure(256 * stepc, 1'b1, "commit");
    wr(8'h26, 8'h01);
    measure(1000, 1'b0, "global");
    wr(8'h26, 8'h00);
    wr(8'h00, 8'h00);
    measure(1000, 1'b0, "soft");
    wr(8'h00, 8'h01);
    hw_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    measure(1000, 1'b0, "pin");
    hw_n <= 1'b1;
    wr(8'h27, 8'h01);
    wr(8'h2f, 8'h05);
    stepc = `LPB_CLK_HZ / (`LPB_SLOW_PWM_HZ * `LPB_PWM_STEPS);
    measure(256 * stepc, 1'b1, "slow");
    wr(8'h2f, 8'h00);
    foreach (duty_a[i]) begin
      duty_a[i] = 8'h00;
      lvl_a[i] = 5'h00;
    end
    duty_a[0] = 8'h80;
    lvl_a[0] = 5'h18;
    wr(8'h01, 8'h80);
    wr(8'h14, 8'h30);
    wr(8'h00, 8'h01);
    wr(8'h13, 8'h00);
    stepc = `LPB_CLK_HZ / (`LPB_FAST_PWM_HZ * `LPB_PWM_STEPS);
    measure(256 * stepc, 1'b1, "regreset");
    sys_rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    duty_a[0] = 8'h00;
    lvl_a[0] = 5'h00;
    measure(1000, 1'b1, "rerun");
    for (int k = 0; k < 2; k++) begin
      q.delete();
      q.push_back(k ? {5'h1b, strap, 1'b1} : {5'h1b, ~strap, 1'b0});
      q.push_back(8'h00);
      q.push_back(8'h00);
      host_u.xfer(q, acks);
      check(acks, 0);
    end
    $display("test address done");
    finish_test();
  end
endmodule : tb
